// ===== hw/sgps_regs.vh
// register offsets, field positions, reset values and timing counts of the
// switchgear position supervisor; included by the design files only.
// Contract
// - position code: 0 indet, 1 open, 2 closed, 3 disturbed
// - close command starts close timer, indeterminate
// - open command starts open timer, indeterminate
// - timer expiry without feedback gives disturbed, code 3
// - both contacts equal while moving: code 0
// - contacts sampled continuously, 10 closed, 01 open
// - command output ends at timeout or feedback
// - removed plug forces element position open
// - removed element ignores position signal changes
// - withdrawable unit is element plus truck instance
// - element operable with truck withdrawn or inserted
// - per-instance close, open and dwell times
// - single contact gives reduced supervision only
// - protection commands may share command relays
`ifndef SGPS_REGS_VH
`define SGPS_REGS_VH
`define SGPS_OFF_CTRL      12'h000
`define SGPS_OFF_STATUS    12'h004
`define SGPS_OFF_IRQ_STAT  12'h008
`define SGPS_OFF_IRQ_MASK  12'h00C
`define SGPS_OFF_EL_TON    12'h010
`define SGPS_OFF_EL_TOFF   12'h014
`define SGPS_OFF_EL_TDWELL 12'h018
`define SGPS_OFF_TR_TON    12'h020
`define SGPS_OFF_TR_TOFF   12'h024
`define SGPS_OFF_TR_TDWELL 12'h028
`define SGPS_OFF_WIRING    12'h030
// ctrl bits (write 1 = command pulse, except prot_share)
`define SGPS_CTRL_EL_CLOSE 0
`define SGPS_CTRL_EL_OPEN  1
`define SGPS_CTRL_TR_CLOSE 2
`define SGPS_CTRL_TR_OPEN  3
`define SGPS_CTRL_SHARE    8
// wiring: bit0 closed wired, bit1 open wired (element), bits 2/3 truck
`define SGPS_WIRING_RST    4'hF
// position codes
`define SGPS_POS_INDET     2'h0
`define SGPS_POS_OPEN      2'h1
`define SGPS_POS_CLOSED    2'h2
`define SGPS_POS_DISTURB   2'h3
// timers count ticks of 1 ms
`define SGPS_TICK_US       1000
`define SGPS_CLK_MHZ       50
`define SGPS_TICK_CYC      (`SGPS_TICK_US * `SGPS_CLK_MHZ)
// last prescaler count, one below SGPS_TICK_CYC, at the counter's width
`define SGPS_TICK_LAST     16'hC34F
`define SGPS_TON_RST       16'h0064
`define SGPS_TOFF_RST      16'h0064
`define SGPS_TDWELL_RST    16'h0000
`endif

// ===== hw/sgps_instance.v
// one switchgear instance: position validation, moving and dwell timers,
// command output shaping. contacts arrive already synchronised.
`timescale 1ns/100ps
`include "sgps_regs.vh"
module sgps_instance
(
  input  wire        pclk,        // system clock
  input  wire        presetn,     // async reset, low
  input  wire        tick,        // timer tick pulse
  input  wire        aux_closed,  // synced closed contact
  input  wire        aux_open,    // synced open contact
  input  wire [1:0]  wired,       // bit0 closed wired, bit1 open wired
  input  wire        removed,     // plug removed (element only)
  input  wire        cmd_close,   // close request pulse
  input  wire        cmd_open,    // open request pulse
  input  wire [15:0] t_move_on,   // close moving time, ticks
  input  wire [15:0] t_move_off,  // open moving time, ticks
  input  wire [15:0] t_dwell,     // dwell time, ticks
  output reg  [1:0]  pos,         // position code
  output wire        out_close,   // close relay
  output wire        out_open,    // open relay
  output wire        ev_done,     // pulse: move confirmed
  output wire        ev_fail      // pulse: move timed out
);
  localparam ST_IDLE  = 2'd0;
  localparam ST_CLOSE = 2'd1;
  localparam ST_OPEN  = 2'd2;
  localparam ST_DWELL = 2'd3;
  reg [1:0]  state_ff;
  reg [1:0]  nxt_state;
  reg [15:0] cnt_ff;
  reg [15:0] nxt_cnt;
  reg        disturb_ff;
  reg        nxt_disturb;
  reg        done_ff;
  reg        fail_ff;
  wire       at_closed;
  wire       at_open;
  wire       moving;
  // missing contact is inferred from the other one
  assign at_closed = wired[0] ? (aux_closed & ~(wired[1] & aux_open)) : ~aux_open;
  assign at_open   = wired[1] ? (aux_open & ~(wired[0] & aux_closed)) : ~aux_closed;
  assign moving    = (state_ff == ST_CLOSE) || (state_ff == ST_OPEN);
  assign out_close = (state_ff == ST_CLOSE) & ~removed;
  assign out_open  = (state_ff == ST_OPEN) & ~removed;
  assign ev_done   = done_ff;
  assign ev_fail   = fail_ff;
  always @*
  begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_disturb = disturb_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (removed)
        begin
          nxt_disturb = 1'b0;
        end
        else if (cmd_close)
        begin
          nxt_state = ST_CLOSE;
          nxt_cnt   = t_move_on;
        end
        else if (cmd_open)
        begin
          nxt_state = ST_OPEN;
          nxt_cnt   = t_move_off;
        end
        else if (at_closed || at_open)
          nxt_disturb = 1'b0;
      end
      ST_CLOSE, ST_OPEN:
      begin
        if (removed)
          nxt_state = ST_IDLE;
        else if ((state_ff == ST_CLOSE) ? at_closed : at_open)
        begin
          nxt_state   = ST_IDLE;
          nxt_disturb = 1'b0;
        end
        else if (cnt_ff == 16'h0000)
        begin
          nxt_disturb = 1'b1;
          nxt_state   = (t_dwell != 16'h0000) ? ST_DWELL : ST_IDLE;
          nxt_cnt     = t_dwell;
        end
        else if (tick)
          nxt_cnt = cnt_ff - 16'h0001;
      end
      ST_DWELL:
      begin
        if (removed || cnt_ff == 16'h0000)
          nxt_state = ST_IDLE;
        else if (tick)
          nxt_cnt = cnt_ff - 16'h0001;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff   <= ST_IDLE;
      cnt_ff     <= 16'h0000;
      disturb_ff <= 1'b0;
      done_ff    <= 1'b0;
      fail_ff    <= 1'b0;
    end
    else
    begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      disturb_ff <= nxt_disturb;
      done_ff    <= moving && !removed && (nxt_state == ST_IDLE) && !nxt_disturb;
      fail_ff    <= moving && nxt_disturb && !disturb_ff;
    end
  end
  // position code from contacts and supervision state
  always @*
  begin
    if (removed)
      pos = `SGPS_POS_OPEN;
    else if (moving)
      pos = at_closed ? `SGPS_POS_CLOSED : (at_open ? `SGPS_POS_OPEN : `SGPS_POS_INDET);
    else if (state_ff == ST_DWELL)
      pos = `SGPS_POS_INDET;
    else if (wired == 2'b00)
      pos = `SGPS_POS_DISTURB;
    else if (at_closed && !disturb_ff)
      pos = `SGPS_POS_CLOSED;
    else if (at_open && !disturb_ff)
      pos = `SGPS_POS_OPEN;
    else
      pos = `SGPS_POS_DISTURB;
  end
endmodule

// ===== hw/sgps_top.v
// withdrawable switchgear supervisor: switching element plus movable truck,
// APB register slave, interrupt. contact and plug pins are asynchronous.
// protection requests come from logic on pclk and skip the synchronisers.
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/100ps
`include "sgps_regs.vh"
module sgps_top
(
  input  wire        pclk,          // 50 MHz clock
  input  wire        presetn,       // async reset, low
  input  wire        psel,          // apb select
  input  wire        penable,       // apb enable
  input  wire        pwrite,        // apb write
  input  wire [11:0] paddr,         // apb byte address
  input  wire [31:0] pwdata,        // apb write data
  output reg  [31:0] prdata,        // apb read data
  output wire        pready,        // apb ready
  output wire        pslverr,       // apb error
  input  wire        el_aux_closed, // element closed contact pin
  input  wire        el_aux_open,   // element open contact pin
  input  wire        el_ready,      // element ready pin
  input  wire        el_removed,    // control plug removed pin
  input  wire        tr_aux_closed, // truck inserted contact pin
  input  wire        tr_aux_open,   // truck withdrawn contact pin
  input  wire        prot_close,    // protection close request, pulse
  input  wire        prot_open,     // protection open request, pulse
  output wire        el_relay_close,// element close relay
  output wire        el_relay_open, // element open relay
  output wire        prot_relay_close, // separate protection close relay
  output wire        prot_relay_open,  // separate protection open relay
  output wire        tr_relay_close,// truck insert relay
  output wire        tr_relay_open, // truck withdraw relay
  output wire [1:0]  el_pos,        // element position code
  output wire [1:0]  tr_pos,        // truck position code
  output wire        irq            // interrupt, level high
);
  reg  [5:0]  sync1_ff;
  reg  [5:0]  sync2_ff;
  reg  [15:0] tickcnt_ff;
  reg         tick_ff;
  reg         share_ff;
  reg  [3:0]  wiring_ff;
  reg  [15:0] el_ton_ff;
  reg  [15:0] el_toff_ff;
  reg  [15:0] el_tdw_ff;
  reg  [15:0] tr_ton_ff;
  reg  [15:0] tr_toff_ff;
  reg  [15:0] tr_tdw_ff;
  reg  [3:0]  cmd_ff;
  reg  [3:0]  prot_ff;
  reg  [5:0]  istat_ff;
  reg  [5:0]  imask_ff;
  reg  [31:0] nxt_prdata;
  reg  [1:0]  prev_pos_ff;
  wire        wr_en;
  wire        rd_en;
  wire        hit;
  wire        el_c;
  wire        el_o;
  wire        el_rm;
  wire        tr_c;
  wire        tr_o;
  wire [5:0]  ev;
  wire        el_done;
  wire        el_fail;
  wire        tr_done;
  wire        tr_fail;
  wire        el_move_close;
  wire        el_move_open;
  wire        el_sup_close;
  wire        el_sup_open;
  wire        el_ready_s;
  wire        ctrl_wr;
  wire [5:0]  w1c;
  wire [31:0] status_word;
  localparam [15:0] TICK_LAST = `SGPS_TICK_LAST;
  // one address decoder feeds both the error response and the write strobe
  function is_reg;
    input [11:0] a;
    begin
      is_reg = (a == `SGPS_OFF_CTRL) || (a == `SGPS_OFF_STATUS) ||
               (a == `SGPS_OFF_IRQ_STAT) || (a == `SGPS_OFF_IRQ_MASK) ||
               (a == `SGPS_OFF_EL_TON) || (a == `SGPS_OFF_EL_TOFF) ||
               (a == `SGPS_OFF_EL_TDWELL) || (a == `SGPS_OFF_TR_TON) ||
               (a == `SGPS_OFF_TR_TOFF) || (a == `SGPS_OFF_TR_TDWELL) ||
               (a == `SGPS_OFF_WIRING);
    end
  endfunction
  assign pready  = 1'b1;
  assign hit     = is_reg(paddr);
  assign pslverr = psel & penable & ~hit;
  assign wr_en   = psel & penable & pwrite & hit;
  assign rd_en   = psel & ~penable & ~pwrite;
  // two-stage synchronisers on all asynchronous pins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync1_ff <= 6'h00;
    else
      sync1_ff <= {tr_aux_open, tr_aux_closed, el_ready, el_removed, el_aux_open,
                   el_aux_closed};
  end
  // only the second stage is read; the first may still be settling
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync2_ff <= 6'h00;
    else
      sync2_ff <= sync1_ff;
  end
  assign el_c       = sync2_ff[0];
  assign el_o       = sync2_ff[1];
  assign el_rm      = sync2_ff[2];
  assign el_ready_s = sync2_ff[3];
  assign tr_c       = sync2_ff[4];
  assign tr_o       = sync2_ff[5];
  // timer tick prescaler
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tickcnt_ff <= 16'h0000;
    else
      tickcnt_ff <= (tickcnt_ff == TICK_LAST) ? 16'h0000 : tickcnt_ff + 16'h0001;
  end
  // tick is registered so both instances see the same one-cycle pulse
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_ff <= 1'b0;
    else
      tick_ff <= (tickcnt_ff == TICK_LAST);
  end
  // with sharing on, protection commands join element supervision; ready gates the register close command
  assign el_sup_close = (cmd_ff[0] & el_ready_s) | (share_ff & prot_ff[0]);
  assign el_sup_open  = cmd_ff[1] | (share_ff & prot_ff[1]);
  // two independent instances, not interlocked with each other
  sgps_instance u_element
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .tick       (tick_ff),
    .aux_closed (el_c),
    .aux_open   (el_o),
    .wired      (wiring_ff[1:0]),
    .removed    (el_rm),
    .cmd_close  (el_sup_close),
    .cmd_open   (el_sup_open),
    .t_move_on  (el_ton_ff),
    .t_move_off (el_toff_ff),
    .t_dwell    (el_tdw_ff),
    .pos        (el_pos),
    .out_close  (el_move_close),
    .out_open   (el_move_open),
    .ev_done    (el_done),
    .ev_fail    (el_fail)
  );
  sgps_instance u_truck
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .tick       (tick_ff),
    .aux_closed (tr_c),
    .aux_open   (tr_o),
    .wired      (wiring_ff[3:2]),
    .removed    (1'b0),
    .cmd_close  (cmd_ff[2]),
    .cmd_open   (cmd_ff[3]),
    .t_move_on  (tr_ton_ff),
    .t_move_off (tr_toff_ff),
    .t_dwell    (tr_tdw_ff),
    .pos        (tr_pos),
    .out_close  (tr_relay_close),
    .out_open   (tr_relay_open),
    .ev_done    (tr_done),
    .ev_fail    (tr_fail)
  );
  assign el_relay_close   = el_move_close;
  assign el_relay_open    = el_move_open;
  // without sharing, protection pulses go to their own relays unless the plug is removed
  assign prot_relay_close = ~share_ff & prot_ff[0] & ~el_rm;
  assign prot_relay_open  = ~share_ff & prot_ff[1] & ~el_rm;
  assign ev = {(el_pos != prev_pos_ff), el_rm, tr_fail, tr_done, el_fail, el_done};
  assign irq = |(istat_ff & imask_ff);
  assign ctrl_wr = wr_en && (paddr == `SGPS_OFF_CTRL);
  assign w1c     = (wr_en && paddr == `SGPS_OFF_IRQ_STAT) ? pwdata[5:0] : 6'h00;
  // status word: positions, relay levels, plug and ready pins
  assign status_word = {20'h0, el_ready_s, el_rm, tr_relay_open, tr_relay_close,
                        el_relay_open, el_relay_close, tr_pos, 2'b00, el_pos};
  // command bits are strobes: they last one cycle and read back as zero
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmd_ff <= 4'h0;
    else
      cmd_ff <= ctrl_wr ? pwdata[3:0] : 4'h0;
  end
  // protection pulses get one stage so they line up with the commands
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prot_ff <= 4'h0;
    else
      prot_ff <= {2'b00, prot_open, prot_close};
  end
  // previous element code, so that any change of position raises an event
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_pos_ff <= `SGPS_POS_INDET;
    else
      prev_pos_ff <= el_pos;
  end
  // set wins over write-one-to-clear, so an event in the clear cycle is kept
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      istat_ff <= 6'h00;
    else
      istat_ff <= (istat_ff & ~w1c) | ev;
  end
  // read data is taken in the setup cycle and stands through the access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_en)
      prdata <= nxt_prdata;
  end
  // control, mask and wiring settings
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      share_ff  <= 1'b0;
      imask_ff  <= 6'h00;
      wiring_ff <= `SGPS_WIRING_RST;
    end
    else if (wr_en)
    begin
      case (paddr)
        `SGPS_OFF_CTRL:     share_ff  <= pwdata[`SGPS_CTRL_SHARE];
        `SGPS_OFF_IRQ_MASK: imask_ff  <= pwdata[5:0];
        `SGPS_OFF_WIRING:   wiring_ff <= pwdata[3:0];
        default:            share_ff  <= share_ff;
      endcase
    end
  end
  // element moving and dwell times
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      el_ton_ff  <= `SGPS_TON_RST;
      el_toff_ff <= `SGPS_TOFF_RST;
      el_tdw_ff  <= `SGPS_TDWELL_RST;
    end
    else if (wr_en)
    begin
      case (paddr)
        `SGPS_OFF_EL_TON:    el_ton_ff  <= pwdata[15:0];
        `SGPS_OFF_EL_TOFF:   el_toff_ff <= pwdata[15:0];
        `SGPS_OFF_EL_TDWELL: el_tdw_ff  <= pwdata[15:0];
        default:             el_ton_ff  <= el_ton_ff;
      endcase
    end
  end
  // truck moving and dwell times
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tr_ton_ff  <= `SGPS_TON_RST;
      tr_toff_ff <= `SGPS_TOFF_RST;
      tr_tdw_ff  <= `SGPS_TDWELL_RST;
    end
    else if (wr_en)
    begin
      case (paddr)
        `SGPS_OFF_TR_TON:    tr_ton_ff  <= pwdata[15:0];
        `SGPS_OFF_TR_TOFF:   tr_toff_ff <= pwdata[15:0];
        `SGPS_OFF_TR_TDWELL: tr_tdw_ff  <= pwdata[15:0];
        default:             tr_ton_ff  <= tr_ton_ff;
      endcase
    end
  end
  // read mux; unmapped offsets read as zero
  always @*
  begin
    case (paddr)
      `SGPS_OFF_CTRL:      nxt_prdata = {23'h0, share_ff, 8'h00};
      `SGPS_OFF_STATUS:    nxt_prdata = status_word;
      `SGPS_OFF_IRQ_STAT:  nxt_prdata = {26'h0, istat_ff};
      `SGPS_OFF_IRQ_MASK:  nxt_prdata = {26'h0, imask_ff};
      `SGPS_OFF_EL_TON:    nxt_prdata = {16'h0, el_ton_ff};
      `SGPS_OFF_EL_TOFF:   nxt_prdata = {16'h0, el_toff_ff};
      `SGPS_OFF_EL_TDWELL: nxt_prdata = {16'h0, el_tdw_ff};
      `SGPS_OFF_TR_TON:    nxt_prdata = {16'h0, tr_ton_ff};
      `SGPS_OFF_TR_TOFF:   nxt_prdata = {16'h0, tr_toff_ff};
      `SGPS_OFF_TR_TDWELL: nxt_prdata = {16'h0, tr_tdw_ff};
      `SGPS_OFF_WIRING:    nxt_prdata = {28'h0, wiring_ff};
      default:             nxt_prdata = 32'h00000000;
    endcase
  end
endmodule

// ===== tb/sgps_chk.sv
// port assertions for sgps_top
// bound into every sgps_top below; one clock, async low reset
`timescale 1ns/100ps
module sgps_chk
(
  input wire logic       pclk,             // clock
  input wire logic       presetn,          // reset, low
  input wire logic       el_aux_closed,    // element closed pin
  input wire logic       el_aux_open,      // element open pin
  input wire logic       el_removed,       // plug removed pin
  input wire logic       tr_aux_closed,    // truck inserted pin
  input wire logic       tr_aux_open,      // truck withdrawn pin
  input wire logic       el_relay_close,   // element close relay
  input wire logic       el_relay_open,    // element open relay
  input wire logic       prot_relay_close, // protection close relay
  input wire logic       tr_relay_close,   // truck insert relay
  input wire logic       tr_relay_open,    // truck withdraw relay
  input wire logic [1:0] el_pos,           // element code
  input wire logic [1:0] tr_pos            // truck code
);
  // pins pass a two-stage synchroniser, so every cause except the protection relay's is held a few cycles
  wire el_idle = !el_relay_close && !el_relay_open && !el_removed;
  wire tr_idle = !tr_relay_close && !tr_relay_open;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rm_pos; el_removed [*4] |-> el_pos == 2'h1; endproperty
  a_rm_pos: assert property (p_rm_pos) else $error("removed element not open");
  property p_rm_rly; el_removed [*4] |-> !el_relay_close && !el_relay_open; endproperty
  a_rm_rly: assert property (p_rm_rly) else $error("removed element commanded");
  property p_op_pos; (el_idle && el_aux_open && !el_aux_closed) [*4] |-> el_pos == 2'h1;
  endproperty
  a_op_pos: assert property (p_op_pos) else $error("open contacts not code 1");
  property p_cl_pos; (el_idle && el_aux_closed && !el_aux_open) [*5] |-> el_pos == 2'h2;
  endproperty
  a_cl_pos: assert property (p_cl_pos) else $error("closed contacts not code 2");
  property p_move; (el_relay_close && !el_aux_closed && !el_aux_open) [*4] |-> el_pos == 2'h0;
  endproperty
  a_move: assert property (p_move) else $error("moving not indeterminate");
  property p_cl_end; (el_aux_closed && !el_aux_open) [*5] |-> !el_relay_close; endproperty
  a_cl_end: assert property (p_cl_end) else $error("close relay held after feedback");
  property p_op_end; (el_aux_open && !el_aux_closed) [*5] |-> !el_relay_open; endproperty
  a_op_end: assert property (p_op_end) else $error("open relay held after feedback");
  property p_tr_pos; (tr_idle && tr_aux_closed && !tr_aux_open) [*4] |-> tr_pos == 2'h2;
  endproperty
  a_tr_pos: assert property (p_tr_pos) else $error("truck code wrong");
  property p_prot; prot_relay_close |=> !prot_relay_close; endproperty
  a_prot: assert property (p_prot) else $error("protection pulse too long");
endmodule
bind sgps_top sgps_chk u_chk (.pclk, .presetn, .el_aux_closed, .el_aux_open, .el_removed,
  .tr_aux_closed, .tr_aux_open, .el_relay_close, .el_relay_open, .prot_relay_close,
  .tr_relay_close, .tr_relay_open, .el_pos, .tr_pos);

// ===== tb/sgps_gear_model.sv
// switchgear stand-in: contacts follow the relay levels after a travel time
// stuck freezes it mid travel (both contacts 0), flip swaps the contacts
`timescale 1ns/100ps
module sgps_gear_model
#(
  parameter int TRAVEL = 20
)
(
  input  wire logic pclk,   // clock
  input  wire logic cmd_cl, // close relay
  input  wire logic cmd_op, // open relay
  input  wire logic stuck,  // never arrive
  input  wire logic flip,   // tampered contacts
  output logic      aux_cl, // closed contact
  output logic      aux_op, // open contact
  output logic      ready   // drive ready
);
  logic is_cl_ff = 1'b0;
  logic moving_ff = 1'b0;
  int   cnt_ff = 0;
  assign ready = 1'b1;
  // both contacts wired; mid travel neither is made
  assign aux_cl = moving_ff ? 1'b0 : (is_cl_ff ^ flip);
  assign aux_op = moving_ff ? 1'b0 : (!is_cl_ff ^ flip);
  always @(posedge pclk)
    if (!moving_ff && ((cmd_cl && !is_cl_ff) || (cmd_op && is_cl_ff)))
    begin
      moving_ff <= 1'b1;
      cnt_ff <= TRAVEL;
    end
    else if (moving_ff && !stuck && cnt_ff == 0)
    begin
      moving_ff <= 1'b0;
      is_cl_ff <= !is_cl_ff;
    end
    else if (moving_ff && !stuck)
      cnt_ff <= cnt_ff - 1;
endmodule

// ===== tb/switchgear_position_supervisor_bench.sv
// self-checking bench for sgps_top with two switchgear stand-ins
// drives inputs after rising edges, samples APB read data, the in-reset outputs and irq after a read at rising edges, other outputs at falling edges
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %0t got %0h want %0h", $time, g, e); end end
`define WAITF(c, n) begin wk = 0; while (!(c) && wk < (n)) begin @(negedge pclk); \
  wk++; end if (!(c)) begin fails++; tally_and_finish(); end end
module switchgear_position_supervisor_bench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic        el_removed = 1'b0, prot_close = 1'b0, prot_open = 1'b0;
  logic        stuck = 1'b0, flip = 1'b0, err;
  wire  [31:0] prdata;
  wire  [1:0]  el_pos, tr_pos;
  wire         pready, pslverr, el_aux_closed, el_aux_open, el_ready, tr_aux_closed;
  wire         tr_aux_open, el_relay_close, el_relay_open, prot_relay_close;
  wire         prot_relay_open, tr_relay_close, tr_relay_open, irq;
  wire  [3:0]  rly = {tr_relay_open, tr_relay_close, el_relay_open, el_relay_close};
  int          fails = 0, n_compared = 0, wk;
  typedef struct packed { logic [11:0] a; logic [31:0] v; logic e; } sgps_row_t;
  sgps_row_t   rows [10] = '{'{12'h000, 32'h0, 1'b0}, '{12'h004, 32'h811, 1'b0},
    '{12'h00C, 32'h0, 1'b0}, '{12'h010, 32'h64, 1'b0}, '{12'h014, 32'h64, 1'b0},
    '{12'h018, 32'h0, 1'b0}, '{12'h020, 32'h64, 1'b0}, '{12'h028, 32'h0, 1'b0},
    '{12'h030, 32'hF, 1'b0}, '{12'h040, 32'h0, 1'b1}};
  sgps_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .el_aux_closed, .el_aux_open, .el_ready, .el_removed, .tr_aux_closed,
    .tr_aux_open, .prot_close, .prot_open, .el_relay_close, .el_relay_open, .prot_relay_close,
    .prot_relay_open, .tr_relay_close, .tr_relay_open, .el_pos, .tr_pos, .irq);
  sgps_gear_model u_el (.pclk, .cmd_cl(el_relay_close), .cmd_op(el_relay_open), .stuck,
    .flip, .aux_cl(el_aux_closed), .aux_op(el_aux_open), .ready(el_ready));
  sgps_gear_model u_tr (.pclk, .cmd_cl(tr_relay_close), .cmd_op(tr_relay_open),
    .stuck(1'b0), .flip(1'b0), .aux_cl(tr_aux_closed), .aux_op(tr_aux_open), .ready());
  task tally_and_finish;
    begin
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20)
      begin
        @(posedge pclk);
        k++;
      end
      if (pready !== 1'b1)
      begin
        fails++;
        tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // k picks the ctrl bit and relay; bits 2 and 3 belong to the truck
  task move(input int k, input int lim, input logic [1:0] exp);
    begin
      apb(1'b1, 12'h000, 32'h1 << k);
      `WAITF(rly[k], 10)
      repeat (8) @(negedge pclk);
      `CHK(k[1] ? tr_pos : el_pos, 2'h0)
      `WAITF(!rly[k], lim)
      repeat (2) @(negedge pclk);
      `CHK(k[1] ? tr_pos : el_pos, exp)
    end
  endtask
  initial forever #10 pclk = ~pclk;
  initial
  begin
    repeat (16) @(posedge pclk);
    `CHK({el_relay_close, el_relay_open, tr_relay_close, tr_relay_open, irq}, 5'h00)
    presetn <= 1'b1;
    repeat (6) @(negedge pclk);
    `CHK(el_pos, 2'h1)
    foreach (rows[i])
    begin
      apb(1'b0, rows[i].a, 32'h0);
      `CHK(rd, rows[i].v)
      `CHK(err, rows[i].e)
    end
    apb(1'b1, 12'h00C, 32'h3);
    apb(1'b1, 12'h008, 32'h3F);
    move(0, 100, 2'h2);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd[1:0], 2'h1)
    repeat (2) @(negedge pclk);
    `CHK(irq, 1'b1)
    apb(1'b1, 12'h00C, 32'h0);
    repeat (2) @(negedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, 12'h00C, 32'h3);
    apb(1'b1, 12'h008, 32'h1);
    repeat (2) @(negedge pclk);
    `CHK(irq, 1'b0)
    move(1, 100, 2'h1);
    move(2, 100, 2'h2);
    move(0, 100, 2'h2);
    move(1, 100, 2'h1);
    move(3, 100, 2'h1);
    @(posedge pclk);
    el_removed <= 1'b1;
    flip <= 1'b1;
    repeat (6) @(negedge pclk);
    `CHK(el_pos, 2'h1)
    apb(1'b1, 12'h000, 32'h1);
    repeat (6) @(negedge pclk);
    `CHK(el_relay_close, 1'b0)
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[10], 1'b1)
    flip <= 1'b0;
    repeat (4) @(posedge pclk);
    el_removed <= 1'b0;
    repeat (6) @(negedge pclk);
    `CHK(el_pos, 2'h1)
    // one tick of moving time keeps the timeout run within 50000 cycles, under the 60000 limit
    apb(1'b1, 12'h010, 32'h1);
    stuck <= 1'b1;
    move(0, 60000, 2'h3);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd[1], 1'b1)
    `CHK(irq, 1'b1)
    stuck <= 1'b0;
    `WAITF(el_pos == 2'h2, 200)
    @(posedge pclk);
    prot_close <= 1'b1;
    @(posedge pclk);
    prot_close <= 1'b0;
    `WAITF(prot_relay_close, 5)
    `CHK(el_relay_close, 1'b0)
    apb(1'b1, 12'h000, 32'h100);
    prot_open <= 1'b1;
    @(posedge pclk);
    prot_open <= 1'b0;
    `WAITF(el_relay_open, 10)
    `WAITF(!el_relay_open, 100)
    repeat (2) @(negedge pclk);
    `CHK(el_pos, 2'h1)
    tally_and_finish();
  end
endmodule
